// file: tsp_cmd_port.sv
// Purpose: command decoder and report formatter of the touch sensor serial port
// Assumes: host is link master, MOSI sampled and MISO launched on LINK_SCK rising edge
// Notes: reply word frozen while select is low; host leaves 50 ns idle around frames
// Operation
// - frames are three bytes each way, host clocked
// - command type sits in byte 0 bits 7..5
// - settings apply only after all three bytes
// - key select: 000 all keys, else one key
// - key recalibrate bit starts key recalibration
// - wheel recalibrate bit starts wheel recalibration
// - held recalibrate bit keeps channels recalibrating
// - all channels recalibrate after power-up
// - resolution codes 001..111 give 2..8 bits
// - new resolution applies from next touch
// - reply answers previous command, normal after reset
// - threshold loaded flag sticks until reset
// - legacy proximity flag always reads zero
// - low power flag reflects mode at request
// - key error flag; recalibrate after 1.5 s
// - wheel error flag; recalibrate after six cycles
// - key calibrating flag while keys calibrate
// - wheel calibrating flag while wheel calibrates
// - byte 1 carries key and wheel touch bits
// - byte 2 holds last touch position
// - threshold load sets wheel threshold, default 30
// - detect level is threshold plus quarter hysteresis
// - debug request answered on following frame
// - debug select picks reference or signed delta
// - debug channel is low nibble of byte 1
// - debug reply: state, value low, value high
`timescale 1ns/1ps
`default_nettype none
`include "tsp_defs.svh"

module tsp_cmd_port #(
  parameter int KEY_ERR_CYCLES = `TSP_KEY_ERR_CYCLES,
  parameter int KEYS = 7
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic LINK_SCK,
  input wire logic LINK_SEL_N,
  input wire logic LINK_MOSI,
  output logic LINK_MISO,
  output logic LINK_MISO_OE,
  input wire logic [KEYS-1:0] KEY_TOUCH,
  input wire logic WHEEL_TOUCH,
  input wire logic [7:0] WHEEL_POSITION,
  input wire logic [KEYS-1:0] KEY_ERROR,
  input wire logic WHEEL_ERROR,
  input wire logic CYCLE_DONE,
  input wire logic [KEYS-1:0] KEY_CALIBRATING,
  input wire logic WHEEL_CALIBRATING,
  input wire logic LOW_POWER_MODE,
  input wire logic [7:0] DBG_STATE,
  input wire logic [15:0] DBG_VALUE,
  output logic [KEYS-1:0] KEY_RECAL_REQ,
  output logic WHEEL_RECAL_REQ,
  output logic [7:0] WHEEL_THRESHOLD,
  output logic [8:0] WHEEL_DETECT_LEVEL,
  output logic [3:0] DBG_CHANNEL,
  output logic DBG_SELECT
);

  // ---------------------------------------------
  // link domain
  // ---------------------------------------------
  logic [4:0] bit_cnt_ff; // bits seen in this frame
  logic [22:0] rx_shift_ff; // incoming bits, msb first
  tsp_pkg::tsp_frame_type rx_word_ff; // last complete frame
  logic done_tgl_ff; // flips once per complete frame
  logic link_idle; // clears frame state between frames
  logic [4:0] tx_idx; // reply bit launched on this edge
  tsp_pkg::tsp_frame_type tx_snap_ff; // reply, frozen while selected

  assign link_idle = LINK_SEL_N | SYS_RST;
  assign tx_idx = `TSP_LAST_BIT - bit_cnt_ff;

  // bit counter and reply shifter, cleared by deselect
  always_ff @(posedge LINK_SCK or posedge link_idle)
  begin
    if (link_idle)
    begin
      bit_cnt_ff <= 5'h00;
      LINK_MISO <= 1'b0;
      LINK_MISO_OE <= 1'b0;
    end
    else if (bit_cnt_ff != `TSP_FRAME_BITS) // extra clocks are ignored
    begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      LINK_MISO <= tx_snap_ff[tx_idx];
      LINK_MISO_OE <= 1'b1;
    end
  end

  // data path of the receiver, no reset needed
  always_ff @(posedge LINK_SCK)
  begin
    rx_shift_ff <= {rx_shift_ff[21:0], LINK_MOSI};
    if (bit_cnt_ff == `TSP_LAST_BIT)
      rx_word_ff <= {rx_shift_ff, LINK_MOSI}; // held until next frame ends
  end

  // frame-complete toggle; clock may stop right after
  always_ff @(posedge LINK_SCK or posedge SYS_RST)
  begin
    if (SYS_RST)
      done_tgl_ff <= 1'b0;
    else if (!LINK_SEL_N && bit_cnt_ff == `TSP_LAST_BIT)
      done_tgl_ff <= ~done_tgl_ff;
  end

  // ---------------------------------------------
  // crossing into the system clock
  // ---------------------------------------------
  logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff, tgl_acc_ff; // toggle synchroniser
  logic sel_s1_ff, sel_s2_ff, sel_s3_ff; // select synchroniser
  logic frame_evt; // one pulse per received frame
  logic link_quiet; // select seen high by both late stages

  assign frame_evt = (tgl_s2_ff == tgl_s3_ff) && (tgl_s3_ff != tgl_acc_ff);
  assign link_quiet = sel_s2_ff & sel_s3_ff;

  // three stages; change counts once stages two and three agree
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      {tgl_s1_ff, tgl_s2_ff, tgl_s3_ff, tgl_acc_ff} <= 4'h0;
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <= 3'h7;
    end
    else
    begin
      {tgl_s1_ff, tgl_s2_ff, tgl_s3_ff} <= {done_tgl_ff, tgl_s1_ff, tgl_s2_ff};
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <= {LINK_SEL_N, sel_s1_ff, sel_s2_ff};
      if (frame_evt)
        tgl_acc_ff <= tgl_s3_ff;
    end
  end

  // ---------------------------------------------
  // command decode
  // ---------------------------------------------
  logic [2:0] cmd_type; // byte 0 bits 7..5
  logic is_normal, is_thresh, is_debug; // decoded frame kinds
  logic [2:0] res_code; // byte 2 bits 7..5
  logic [2:0] key_sel; // byte 2 bits 2..0
  logic [KEYS-1:0] key_mask; // keys picked by key_sel
  logic key_recal_request, wheel_recal_request; // recalibrate bits of byte 2

  assign cmd_type = rx_word_ff.b0[7:5];
  assign is_normal = frame_evt && cmd_type == `TSP_CMD_NORMAL;
  assign is_thresh = frame_evt && cmd_type == `TSP_CMD_THRESH;
  assign is_debug = frame_evt && cmd_type == `TSP_CMD_DEBUG;
  assign res_code = rx_word_ff.b2[7:5];
  assign key_sel = rx_word_ff.b2[2:0];
  assign key_recal_request = rx_word_ff.b2[`TSP_B2_KEY_RECAL];
  assign wheel_recal_request = rx_word_ff.b2[`TSP_B2_WHEEL_RECAL];
  // code zero is every key, wheel excluded
  assign key_mask = (key_sel == 3'h0) ? {KEYS{1'b1}} :
    KEYS'(1) << (key_sel - 3'h1);

  // ---------------------------------------------
  // settings held from frames
  // ---------------------------------------------
  logic [KEYS-1:0] host_key_ff; // key recal level from host
  logic host_wheel_ff; // wheel recal level from host
  logic [2:0] res_pend_ff; // resolution for the next touch
  logic loaded_ff; // custom threshold received
  logic low_power_state_ff; // low power state at last request
  tsp_pkg::tsp_reply_type reply_kind_ff; // what the next reply carries

  // all settings move only on a completed frame
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      host_key_ff <= '0;
      host_wheel_ff <= 1'b0;
      res_pend_ff <= `TSP_RES_DEFAULT;
      WHEEL_THRESHOLD <= `TSP_THR_DEFAULT;
      loaded_ff <= 1'b0;
      low_power_state_ff <= 1'b0;
      DBG_CHANNEL <= 4'h0;
      DBG_SELECT <= 1'b0;
      reply_kind_ff <= tsp_pkg::RPL_NORMAL;
    end
    else if (frame_evt)
    begin
      low_power_state_ff <= LOW_POWER_MODE;
      // debug request owes its data to the next frame
      reply_kind_ff <= is_debug ? tsp_pkg::RPL_DEBUG : tsp_pkg::RPL_NORMAL;
      if (is_normal)
      begin
        // a level, so a bit left high keeps recalibrating
        host_key_ff <= key_recal_request ? key_mask : '0;
        host_wheel_ff <= wheel_recal_request;
        if (res_code != `TSP_RES_RESERVED) // reserved code ignored
          res_pend_ff <= res_code;
      end
      if (is_thresh)
      begin
        WHEEL_THRESHOLD <= rx_word_ff.b1;
        loaded_ff <= 1'b1;
      end
      if (is_debug)
      begin
        DBG_CHANNEL <= rx_word_ff.b1[3:0];
        DBG_SELECT <= rx_word_ff.b0[0];
      end
    end
  end

  // ---------------------------------------------
  // detection level
  // ---------------------------------------------
  logic [5:0] hyst; // quarter of threshold, at least one

  assign hyst = (WHEEL_THRESHOLD[7:2] == 6'h00) ? 6'h01 : WHEEL_THRESHOLD[7:2];

  // one cycle behind the threshold itself
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      WHEEL_DETECT_LEVEL <= 9'h000;
    else
      WHEEL_DETECT_LEVEL <= {1'b0, WHEEL_THRESHOLD} + {3'h0, hyst};
  end

  // ---------------------------------------------
  // position and resolution
  // ---------------------------------------------
  logic touch_prev_ff; // wheel touch last cycle
  logic [2:0] res_act_ff; // resolution of the current touch
  logic [2:0] res_use; // resolution applied this cycle
  logic [7:0] pos_ff; // reported position, held after release

  assign res_use = (WHEEL_TOUCH && !touch_prev_ff) ? res_pend_ff : res_act_ff;

  // resolution latched at touch start so a touch never changes scale
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      touch_prev_ff <= 1'b0;
      res_act_ff <= `TSP_RES_DEFAULT;
      pos_ff <= 8'h00;
    end
    else
    begin
      touch_prev_ff <= WHEEL_TOUCH;
      res_act_ff <= res_use;
      if (WHEEL_TOUCH) // no touch keeps last position
        pos_ff <= WHEEL_POSITION >> (3'h7 - res_use);
    end
  end

  // ---------------------------------------------
  // automatic recalibration
  // ---------------------------------------------
  localparam int KW = $clog2(KEY_ERR_CYCLES + 2);
  logic [KEYS-1:0] key_auto; // key error held too long
  logic [2:0] wheel_err_cnt_ff; // consecutive cycles in error
  logic wheel_auto; // sixth error cycle in a row
  logic pwr_ff; // first cycle after reset

  // one timer per key; wide, so per-key cost is accepted
  for (genvar k = 0; k < KEYS; k++)
  begin : g_key
    logic [KW-1:0] err_cnt_ff; // cycles this key stayed in error
    assign key_auto[k] = KEY_ERROR[k] && err_cnt_ff == KW'(KEY_ERR_CYCLES);
    always_ff @(posedge SYS_CLK)
    begin
      if (SYS_RST || !KEY_ERROR[k] || key_auto[k])
        err_cnt_ff <= '0;
      else
        err_cnt_ff <= err_cnt_ff + KW'(1);
    end
  end

  assign wheel_auto = CYCLE_DONE && WHEEL_ERROR
    && wheel_err_cnt_ff == `TSP_WHEEL_ERR_CYCLES - 3'h1;

  // counts measurement cycles, not clocks
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      wheel_err_cnt_ff <= 3'h0;
    else if (CYCLE_DONE)
      wheel_err_cnt_ff <= (!WHEEL_ERROR || wheel_auto) ? 3'h0 : wheel_err_cnt_ff + 3'h1;
  end

  // recalibration requests: host level, auto pulses, power-up pulse
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      pwr_ff <= 1'b1;
      KEY_RECAL_REQ <= '0;
      WHEEL_RECAL_REQ <= 1'b0;
    end
    else
    begin
      pwr_ff <= 1'b0;
      KEY_RECAL_REQ <= host_key_ff | key_auto | {KEYS{pwr_ff}};
      WHEEL_RECAL_REQ <= host_wheel_ff | wheel_auto | pwr_ff;
    end
  end

  // ---------------------------------------------
  // reply formatting
  // ---------------------------------------------
  tsp_pkg::tsp_frame_type rpt_normal; // status and key report
  tsp_pkg::tsp_frame_type rpt_debug; // delayed debug data

  always_comb
  begin
    rpt_normal.b0 = 8'h00; // legacy and unused bits stay zero
    rpt_normal.b0[`TSP_RPT_LOADED] = loaded_ff;
    rpt_normal.b0[`TSP_RPT_PROX] = 1'b0;
    rpt_normal.b0[`TSP_RPT_LOW_POWER] = low_power_state_ff;
    rpt_normal.b0[`TSP_RPT_KEY_ERR] = |KEY_ERROR;
    rpt_normal.b0[`TSP_RPT_WHEEL_ERR] = WHEEL_ERROR;
    rpt_normal.b0[`TSP_RPT_KEY_CAL] = |KEY_CALIBRATING;
    rpt_normal.b0[`TSP_RPT_WHEEL_CAL] = WHEEL_CALIBRATING;
    rpt_normal.b1 = {WHEEL_TOUCH, KEY_TOUCH};
    rpt_normal.b2 = pos_ff;
  end

  assign rpt_debug = {DBG_STATE, DBG_VALUE[7:0], DBG_VALUE[15:8]};

  // snapshot follows live status only while the link is quiet
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      tx_snap_ff <= '0;
    else if (link_quiet && !frame_evt)
      tx_snap_ff <= (reply_kind_ff == tsp_pkg::RPL_DEBUG) ? rpt_debug : rpt_normal;
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  logic [7:0] b1_last; // threshold byte of the frame
  assign b1_last = rx_word_ff.b1;

  sequence thr_cmd_s;
    is_thresh;
  endsequence

  thr_load_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    thr_cmd_s |=> WHEEL_THRESHOLD == $past(b1_last))
    else $error("threshold not loaded from byte 1");

  loaded_sticky_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    loaded_ff |=> loaded_ff && (tx_snap_ff.b0[`TSP_RPT_LOADED] || !$past(link_quiet)
      || $past(frame_evt) || $past(reply_kind_ff) == tsp_pkg::RPL_DEBUG))
    else $error("loaded flag dropped");

  settle_frame_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !frame_evt |=> $stable(WHEEL_THRESHOLD) && $stable(res_pend_ff))
    else $error("setting changed without a frame");

  debug_next_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    reply_kind_ff == tsp_pkg::RPL_DEBUG && link_quiet && !frame_evt |=> tx_snap_ff == $past(rpt_debug))
    else $error("debug reply not prepared");

  key_recal_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    is_normal |=> host_key_ff == ($past(key_recal_request) ? $past(key_mask) : '0))
    else $error("key recal level wrong");

  wheel_recal_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    is_normal && wheel_recal_request |=> ##1 WHEEL_RECAL_REQ)
    else $error("wheel recal not requested");

  power_recal_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    pwr_ff |=> KEY_RECAL_REQ == {KEYS{1'b1}} && WHEEL_RECAL_REQ)
    else $error("no power-up recalibration");

  wheel_err_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CYCLE_DONE && WHEEL_ERROR && wheel_err_cnt_ff == 3'h5 |=> WHEEL_RECAL_REQ)
    else $error("wheel error recal missed");

  res_hold_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    touch_prev_ff && WHEEL_TOUCH |=> $stable(res_act_ff))
    else $error("resolution changed during touch");

  pos_hold_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !WHEEL_TOUCH |=> $stable(pos_ff))
    else $error("position moved without touch");

endmodule : tsp_cmd_port
`default_nettype wire

// file: tsp_cmd_port_test.sv
// Purpose: self-checking bench of the touch sensor command port
// Assumes: tsp_host_model drives the link, bench drives the sensing side
// Notes: key error hold shortened to a few cycles to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tsp_cmd_port_test;
  // ---------------------------------------------
  // bench signals
  // ---------------------------------------------
  localparam int KERR = 20; // short key error hold
  logic sys_clk;
  logic sys_rst;
  logic [6:0] key_touch, key_error, key_cal;
  logic wheel_touch, wheel_error, cycle_done, wheel_cal, low_power;
  logic [7:0] wheel_pos, dbg_state;
  logic [15:0] dbg_value;
  wire logic sck, sel_n, mosi, miso, miso_oe, wheel_req, dbg_sel;
  wire logic [6:0] key_req;
  wire logic [7:0] thr;
  wire logic [8:0] det;
  wire logic [3:0] dbg_ch;
  int n_mismatch, cmp_count, w_hits, k_hits;
  tsp_pkg::tsp_frame_type rx; // last reply word

  tsp_cmd_port #(.KEY_ERR_CYCLES(KERR), .KEYS(7)) u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .LINK_SCK(sck), .LINK_SEL_N(sel_n), .LINK_MOSI(mosi), .LINK_MISO(miso),
    .LINK_MISO_OE(miso_oe), .KEY_TOUCH(key_touch), .WHEEL_TOUCH(wheel_touch),
    .WHEEL_POSITION(wheel_pos), .KEY_ERROR(key_error), .WHEEL_ERROR(wheel_error),
    .CYCLE_DONE(cycle_done), .KEY_CALIBRATING(key_cal), .WHEEL_CALIBRATING(wheel_cal),
    .LOW_POWER_MODE(low_power), .DBG_STATE(dbg_state), .DBG_VALUE(dbg_value),
    .KEY_RECAL_REQ(key_req), .WHEEL_RECAL_REQ(wheel_req), .WHEEL_THRESHOLD(thr),
    .WHEEL_DETECT_LEVEL(det), .DBG_CHANNEL(dbg_ch), .DBG_SELECT(dbg_sel));
  tsp_host_model u_host (.LINK_SCK(sck), .LINK_SEL_N(sel_n), .LINK_MOSI(mosi),
    .LINK_MISO(miso), .LINK_MISO_OE(miso_oe));

  // 200 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // count cycles with a recal request high; sampled mid-cycle, away from the launching edge
  always @(negedge sys_clk)
  begin
    w_hits += (wheel_req === 1'b1);
    k_hits += (key_req[1] === 1'b1);
  end

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // one frame, then time for the settings to cross
  task automatic xch(input logic [23:0] tx);
    u_host.xfer(tx, rx);
    tick(10);
  endtask : xch

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {key_touch, key_error, key_cal, wheel_touch, wheel_error} = '0;
    {cycle_done, wheel_cal, low_power, wheel_pos, dbg_state, dbg_value} = '0;
    tick(16);
    sys_rst = 1'b0;
    tick(1);
    chk({16'h0, wheel_req, key_req}, 24'h0000ff);
    tick(1);
    chk({16'h0, wheel_req, key_req}, 24'h000000);
    chk({7'h0, det, thr}, {7'h0, 9'h025, 8'h1e});
    $display("test reset done");
    // report fields, every status flag set except loaded and proximity
    key_touch = 7'h55;
    key_error = 7'h02;
    key_cal = 7'h01;
    {wheel_error, wheel_cal, low_power} = 3'h7;
    wheel_pos = 8'hc8;
    wheel_touch = 1'b1;
    tick(10);
    xch(24'h0000c0);
    chk({8'h0, rx[15:0]}, 24'h00d564);
    xch(24'h0000c0);
    chk(rx, 24'hf8d564);
    $display("test report done");
    // threshold loads, smallest hysteresis first; byte 2 kept zero
    key_error = 7'h00;
    xch(24'h800400);
    chk(rx, 24'he8d564);
    chk({7'h0, det, thr}, {7'h0, 9'h005, 8'h04});
    xch(24'h806400);
    chk(rx, 24'he9d564);
    chk({7'h0, det, thr}, {7'h0, 9'h07d, 8'h64});
    $display("test threshold done");
    // host recal bits: one key, all keys, then cleared
    xch(24'h0000db);
    chk({16'h0, wheel_req, key_req}, 24'h000084);
    tick(20);
    chk({16'h0, wheel_req, key_req}, 24'h000084);
    xch(24'h0000c8);
    chk({16'h0, wheel_req, key_req}, 24'h00007f);
    xch(24'h0000c0);
    chk({16'h0, wheel_req, key_req}, 24'h000000);
    $display("test recal done");
    // debug request, then version request, then debug with reference
    dbg_state = 8'h08;
    dbg_value = 16'hbeef;
    xch(24'h210900);
    chk({19'h0, dbg_sel, dbg_ch}, 24'h000019);
    xch(24'h400000);
    chk(rx, 24'h08efbe);
    xch(24'h200300);
    chk(rx, 24'he9d564);
    chk({19'h0, dbg_sel, dbg_ch}, 24'h000003);
    xch(24'h0000e0);
    chk(rx, 24'h08efbe);
    $display("test debug done");
    // resolution change waits for the next touch; reserved code ignored
    xch(24'h0000e0);
    chk(rx, 24'he9d564);
    wheel_touch = 1'b0;
    tick(2);
    wheel_touch = 1'b1;
    tick(10);
    xch(24'h000000);
    chk(rx, 24'he9d5c8);
    wheel_touch = 1'b0;
    wheel_pos = 8'h10;
    tick(10);
    xch(24'h000000);
    chk(rx, 24'he955c8);
    wheel_touch = 1'b1;
    tick(10);
    xch(24'h000000);
    chk(rx, 24'he9d510);
    $display("test resolution done");
    // wheel error over six measurement cycles
    w_hits = 0;
    for (int i = 0; i < 6; i++)
    begin
      cycle_done = 1'b1;
      tick(1);
      cycle_done = 1'b0;
      tick(3);
      chk(24'(w_hits), (i == 5) ? 24'h1 : 24'h0);
    end
    // key error held past the shortened hold time
    k_hits = 0;
    key_error = 7'h02;
    tick(KERR - 2);
    chk(24'(k_hits), 24'h0);
    tick(6);
    chk(24'(k_hits), 24'h1);
    key_error = 7'h00;
    $display("test errors done");
    tally_and_finish();
  end
endmodule : tsp_cmd_port_test
`default_nettype wire

// file: tsp_defs.svh
// Purpose: shared constants of the touch sensor command port
// Assumes: included by bare name from the command port design file
// Notes: offsets are bit positions inside one byte of the 24-bit link word
`ifndef TSP_DEFS_SVH
`define TSP_DEFS_SVH

// ---------------------------------------------
// command codes, host byte 0 bits 7..5
// ---------------------------------------------
`define TSP_CMD_NORMAL 3'h0
`define TSP_CMD_DEBUG 3'h1
`define TSP_CMD_VERSION 3'h2
`define TSP_CMD_THRESH 3'h4

// ---------------------------------------------
// host byte 2 field positions
// ---------------------------------------------
`define TSP_B2_WHEEL_RECAL 4
`define TSP_B2_KEY_RECAL 3

// ---------------------------------------------
// report byte 0 field positions
// ---------------------------------------------
`define TSP_RPT_LOADED 0
`define TSP_RPT_PROX 2
`define TSP_RPT_LOW_POWER 3
`define TSP_RPT_KEY_ERR 4
`define TSP_RPT_WHEEL_ERR 5
`define TSP_RPT_KEY_CAL 6
`define TSP_RPT_WHEEL_CAL 7

// ---------------------------------------------
// reset values and counts
// ---------------------------------------------
`define TSP_RES_RESERVED 3'h0
`define TSP_RES_DEFAULT 3'h6
`define TSP_THR_DEFAULT 8'h1e
`define TSP_FRAME_BITS 5'h18
`define TSP_LAST_BIT 5'h17
`define TSP_WHEEL_ERR_CYCLES 3'h6
`define TSP_CLK_KHZ 200000
`define TSP_KEY_ERR_MS 1500
`define TSP_KEY_ERR_CYCLES (`TSP_KEY_ERR_MS * `TSP_CLK_KHZ)

`endif

// file: tsp_host_model.sv
// Purpose: host side of the touch sensor link, acting as link master
// Assumes: device launches data on rising link clock, host samples on falling
// Notes: link clock stands still between frames; released data line reads inverted
`timescale 1ns/1ps
`default_nettype none
module tsp_host_model (
  output logic LINK_SCK,
  output logic LINK_SEL_N,
  output logic LINK_MOSI,
  input wire logic LINK_MISO,
  input wire logic LINK_MISO_OE
);
  // ---------------------------------------------
  // data line seen by the host
  // ---------------------------------------------
  logic last_bit; // last level taken from the device
  wire logic miso_wire; // undriven line must never look like good data
  assign miso_wire = LINK_MISO_OE ? LINK_MISO : ~last_bit;

  // idle levels before the first frame
  initial
  begin
    LINK_SCK = 1'b0;
    LINK_SEL_N = 1'b1;
    LINK_MOSI = 1'b0;
    last_bit = 1'b0;
  end

  // ---------------------------------------------
  // one exchange: three bytes out, three bytes back, byte 0 msb first
  // ---------------------------------------------
  task automatic xfer(input tsp_pkg::tsp_frame_type tx, output tsp_pkg::tsp_frame_type rx);
    logic [23:0] sh;
    logic [23:0] got;
    sh = tx;
    LINK_SEL_N = 1'b0;
    // odd lead time keeps link edges off the system clock grid
    #61.3;
    for (int k = 23; k >= 0; k--)
    begin
      LINK_MOSI = sh[k];
      #7;
      LINK_SCK = 1'b1;
      #15;
      LINK_SCK = 1'b0;
      got[k] = miso_wire;
      last_bit = miso_wire;
      #8;
    end
    #60;
    LINK_SEL_N = 1'b1;
    // host stops driving data; show a changed level, not the stale bit
    LINK_MOSI = ~LINK_MOSI;
    rx = got;
    #150;
  endtask : xfer
endmodule : tsp_host_model
`default_nettype wire

// file: tsp_pkg.sv
// Purpose: types of the touch sensor command port
// Assumes: tsp_defs.svh holds the numbers
// Notes: no imports; users write tsp_pkg::name
`default_nettype none
package tsp_pkg;

  // one three-byte link word, byte 0 first on the wire
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
  } tsp_frame_type;

  // kind of reply owed to the previous command
  typedef enum logic {
    RPL_NORMAL,
    RPL_DEBUG
  } tsp_reply_type;

endpackage : tsp_pkg
`default_nettype wire
